// File: verilog/cfrf_regfile.sv
// Integer and floating-point architectural register file
`timescale 1ns/1ps
`default_nettype none
`include "cfrf_params.svh"

// Operation
// - Thirty-two 32-bit general registers plus a 32-bit program counter.
// - Two separate 32-bit registers catch multiply and divide results.
// - General register zero always reads zero; writes to it are dropped.
// - Register 31 receives the return address on jump-and-link.
// - Thirty-two directly addressable 32-bit fp word registers.
// - Fp word registers are written by load and move, and read by store and move.
// - Adjacent fp word pairs form sixteen 64-bit fp pair registers.
// - A pair register holds either single or double precision values.
// - Two fp control registers, reachable by moves; register zero also takes fpu status updates.
// - Control register zero controls and reports exceptions and modes.
// - Control register one holds read-only fpu revision information.
// - Two integer source reads and one independent destination write.
module cfrf_regfile
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Integer side
   input wire cfrf_pkg::cfrf_idx_t rs_idx_i,
   input wire cfrf_pkg::cfrf_idx_t rt_idx_i,
   output cfrf_pkg::cfrf_word_t rs_data_o,
   output cfrf_pkg::cfrf_word_t rt_data_o,
   input wire cfrf_pkg::cfrf_wr_t gpr_wr_i,
   input wire logic link_en_i,
   input wire cfrf_pkg::cfrf_word_t link_addr_i,
   // Program counter
   input wire logic pc_en_i,
   input wire cfrf_pkg::cfrf_word_t pc_next_i,
   output cfrf_pkg::cfrf_word_t pc_o,
   // Multiply and divide results
   input wire cfrf_pkg::cfrf_md_wr_t md_wr_i,
   input wire logic hi_mv_en_i,
   input wire logic lo_mv_en_i,
   input wire cfrf_pkg::cfrf_word_t md_mv_data_i,
   output cfrf_pkg::cfrf_word_t hi_o,
   output cfrf_pkg::cfrf_word_t lo_o,
   // Floating point words and pairs
   input wire cfrf_pkg::cfrf_idx_t fw_idx_i,
   output cfrf_pkg::cfrf_word_t fw_data_o,
   input wire cfrf_pkg::cfrf_pidx_t fs_pidx_i,
   input wire cfrf_pkg::cfrf_pidx_t ft_pidx_i,
   output logic [63:0] fs_pair_o,
   output logic [63:0] ft_pair_o,
   input wire cfrf_pkg::cfrf_fp_op_t fw_op_i,
   input wire cfrf_pkg::cfrf_wr_t fw_wr_i,
   input wire logic fp_res_en_i,
   input wire logic fp_res_dbl_i,
   input wire cfrf_pkg::cfrf_pidx_t fp_res_pidx_i,
   input wire logic [63:0] fp_res_i,
   // Floating point control, moves plus fpu status update
   input wire logic fc_sel_i,
   output cfrf_pkg::cfrf_word_t fc_data_o,
   input wire logic fc_wr_en_i,
   input wire cfrf_pkg::cfrf_word_t fc_wr_data_i,
   input wire logic fcsr_upd_en_i,
   input wire cfrf_pkg::cfrf_word_t fcsr_upd_i,
   output cfrf_pkg::cfrf_word_t fcsr_o
);
   import cfrf_pkg::*;

   // ----------------------------------------
   // Integer registers
   // ----------------------------------------
   cfrf_word_t gpr_reg [32];
   cfrf_word_t gpr_next [32];
   cfrf_word_t pc_reg;
   cfrf_word_t pc_next;
   cfrf_word_t hi_reg;
   cfrf_word_t hi_next;
   cfrf_word_t lo_reg;
   cfrf_word_t lo_next;
   cfrf_wr_t gw;

   // Link write takes priority over a plain write in the same cycle
   always_comb
   begin
      gw = gpr_wr_i;
      if (link_en_i)
      begin
         gw.en = 1'b1;
         gw.idx = `CFRF_LINK_IDX;
         gw.data = link_addr_i;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++)
      begin : g_gpr
         always_comb
         begin
            gpr_next[gi] = gpr_reg[gi];
            if (gi == 0)
               gpr_next[gi] = `CFRF_WORD_ZERO;
            else if (gw.en && gw.idx == 5'(gi))
               gpr_next[gi] = gw.data;
         end
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               gpr_reg[gi] <= `CFRF_WORD_ZERO;
            else
               gpr_reg[gi] <= gpr_next[gi];
         end
      end
   endgenerate

   // Bypass keeps dependent back-to-back instructions current
   function automatic cfrf_word_t gpr_read(input cfrf_idx_t idx);
      if (idx == `CFRF_ZERO_IDX)
         return `CFRF_WORD_ZERO;
      else if (gw.en && gw.idx == idx)
         return gw.data;
      else
         return gpr_reg[idx];
   endfunction

   // A process, not an assign, so the reads inside the function are watched
   always_comb
   begin
      rs_data_o = gpr_read(rs_idx_i);
      rt_data_o = gpr_read(rt_idx_i);
   end

   always_comb
   begin
      pc_next = pc_en_i ? pc_next_i : pc_reg;
      hi_next = hi_reg;
      lo_next = lo_reg;
      if (md_wr_i.en)
      begin
         hi_next = md_wr_i.hi;
         lo_next = md_wr_i.lo;
      end
      else
      begin
         if (hi_mv_en_i)
            hi_next = md_mv_data_i;
         if (lo_mv_en_i)
            lo_next = md_mv_data_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pc_reg <= `CFRF_PC_RESET;
         hi_reg <= `CFRF_WORD_ZERO;
         lo_reg <= `CFRF_WORD_ZERO;
      end
      else
      begin
         pc_reg <= pc_next;
         hi_reg <= hi_next;
         lo_reg <= lo_next;
      end
   end

   assign pc_o = pc_reg;
   assign hi_o = hi_reg;
   assign lo_o = lo_reg;

   // ----------------------------------------
   // Floating point word registers
   // ----------------------------------------
   cfrf_word_t fw_reg [32];
   cfrf_word_t fw_next [32];
   logic fw_hit;

   // Word port writes come only from loads or moves; stores just read
   assign fw_hit = fw_wr_i.en && (fw_op_i != CFRF_FP_NONE);

   genvar fi;
   generate
      for (fi = 0; fi < 32; fi++)
      begin : g_fw
         always_comb
         begin
            fw_next[fi] = fw_reg[fi];
            if (fp_res_en_i && fp_res_pidx_i == 4'(fi / 2))
            begin
               // Single results touch the even word only
               if (fi % 2 == 0)
                  fw_next[fi] = fp_res_i[31:0];
               else if (fp_res_dbl_i)
                  fw_next[fi] = fp_res_i[63:32];
            end
            if (fw_hit && fw_wr_i.idx == 5'(fi))
               fw_next[fi] = fw_wr_i.data;
         end
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               fw_reg[fi] <= `CFRF_WORD_ZERO;
            else
               fw_reg[fi] <= fw_next[fi];
         end
      end
   endgenerate

   // Reads see the value each word will take at the next edge
   assign fw_data_o = fw_next[fw_idx_i];
   assign fs_pair_o = {fw_next[{fs_pidx_i, 1'b1}], fw_next[{fs_pidx_i, 1'b0}]};
   assign ft_pair_o = {fw_next[{ft_pidx_i, 1'b1}], fw_next[{ft_pidx_i, 1'b0}]};

   // ----------------------------------------
   // Floating point control registers
   // ----------------------------------------
   cfrf_word_t fcsr_reg;
   cfrf_word_t fcsr_next;

   // Revision word is a constant; its value is arbitrary
   always_comb
   begin
      fcsr_next = fcsr_reg;
      if (fcsr_upd_en_i)
         fcsr_next = fcsr_upd_i;
      if (fc_wr_en_i && !fc_sel_i)
         fcsr_next = fc_wr_data_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         fcsr_reg <= `CFRF_CSR_RESET;
      else
         fcsr_reg <= fcsr_next;
   end

   assign fc_data_o = fc_sel_i ? `CFRF_REV_VALUE : fcsr_next;
   assign fcsr_o = fcsr_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_ZERO_READ: assert property (@(posedge clk_i) disable iff (rst_i)
      rs_idx_i == `CFRF_ZERO_IDX |-> rs_data_o == `CFRF_WORD_ZERO)
      else $error("zero register read nonzero");
   AST_GPR_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      gw.en && gw.idx != `CFRF_ZERO_IDX && !link_en_i |=> gpr_reg[$past(gw.idx)] == $past(gw.data))
      else $error("general write lost");
   AST_LINK: assert property (@(posedge clk_i) disable iff (rst_i)
      link_en_i |=> gpr_reg[31] == $past(link_addr_i))
      else $error("link write lost");
   AST_MD: assert property (@(posedge clk_i) disable iff (rst_i)
      md_wr_i.en |=> hi_o == $past(md_wr_i.hi) && lo_o == $past(md_wr_i.lo))
      else $error("multiply divide result lost");
   AST_PC: assert property (@(posedge clk_i) disable iff (rst_i)
      !pc_en_i |=> $stable(pc_o))
      else $error("pc changed without enable");
   AST_BYPASS: assert property (@(posedge clk_i) disable iff (rst_i)
      gw.en && gw.idx == rt_idx_i && rt_idx_i != `CFRF_ZERO_IDX |-> rt_data_o == gw.data)
      else $error("bypass missing");
   AST_FW: assert property (@(posedge clk_i) disable iff (rst_i)
      fw_hit |=> fw_reg[$past(fw_wr_i.idx)] == $past(fw_wr_i.data))
      else $error("fp word write lost");
   AST_PAIR: assert property (@(posedge clk_i) disable iff (rst_i)
      fp_res_en_i && fp_res_dbl_i && !fw_hit ##1 fs_pidx_i == $past(fp_res_pidx_i)
      && !fp_res_en_i && !fw_hit |-> fs_pair_o == $past(fp_res_i))
      else $error("pair write lost");
   AST_REV: assert property (@(posedge clk_i) disable iff (rst_i)
      fc_sel_i |-> fc_data_o == `CFRF_REV_VALUE)
      else $error("revision changed");
   AST_CSR: assert property (@(posedge clk_i) disable iff (rst_i)
      fc_wr_en_i && !fc_sel_i |=> fcsr_o == $past(fc_wr_data_i))
      else $error("control write lost");
   COV_LINK: cover property (@(posedge clk_i) disable iff (rst_i)
      link_en_i ##1 rs_idx_i == `CFRF_LINK_IDX);
   COV_BYP: cover property (@(posedge clk_i) disable iff (rst_i) gw.en && gw.idx == rs_idx_i);
   COV_DBL: cover property (@(posedge clk_i) disable iff (rst_i) fp_res_en_i && fp_res_dbl_i);
   COV_CSR: cover property (@(posedge clk_i) disable iff (rst_i) fc_wr_en_i && !fc_sel_i);
endmodule
`default_nettype wire

// File: verilog/cfrf_params.svh
// Constants for the cpu and fp register file
`ifndef CFRF_PARAMS_SVH
`define CFRF_PARAMS_SVH
`define CFRF_ZERO_IDX 5'h00
`define CFRF_LINK_IDX 5'h1F
`define CFRF_WORD_ZERO 32'h0000_0000
`define CFRF_PC_RESET 32'h0000_0000
`define CFRF_CSR_RESET 32'h0000_0000
`define CFRF_REV_VALUE 32'h0000_0100
`endif

// File: verilog/cfrf_pkg.sv
// Types for the cpu and fp register file
package cfrf_pkg;
   typedef logic [31:0] cfrf_word_t;
   typedef logic [4:0] cfrf_idx_t;
   typedef logic [3:0] cfrf_pidx_t;
   typedef struct packed
   {
      logic en;
      cfrf_idx_t idx;
      cfrf_word_t data;
   } cfrf_wr_t;
   typedef struct packed
   {
      logic en;
      cfrf_word_t hi;
      cfrf_word_t lo;
   } cfrf_md_wr_t;
   typedef enum logic [1:0]
   {
      CFRF_FP_NONE,
      CFRF_FP_LOAD,
      CFRF_FP_MOVE
   } cfrf_fp_op_t;
endpackage

// File: dv/cfrf_pipe_model.sv
// Pipeline-side model that issues register write requests
`timescale 1ns/1ps
`default_nettype none
module cfrf_pipe_model
   import cfrf_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Write requests
   output cfrf_pkg::cfrf_wr_t gpr_o,
   output cfrf_pkg::cfrf_wr_t fw_o,
   output cfrf_pkg::cfrf_fp_op_t op_o,
   output cfrf_pkg::cfrf_md_wr_t md_o,
   output logic [6:0] en_o,
   output cfrf_pkg::cfrf_word_t aux_o,
   // Fpu result
   output logic dbl_o,
   output cfrf_pkg::cfrf_pidx_t pidx_o,
   output logic [63:0] res_o
);
   // Enables drop together; data stays put so late readers see no glitch
   // Requests change one step after the edge so the design samples settled values
   task automatic wait_edge();
      @(posedge clk_i);
      #1;
   endtask
   task automatic idle();
      gpr_o.en = 1'b0;
      fw_o.en = 1'b0;
      md_o.en = 1'b0;
      en_o = 7'h00;
   endtask
   initial
   begin
      gpr_o = '0;
      fw_o = '0;
      md_o = '0;
      en_o = 7'h00;
      op_o = CFRF_FP_NONE;
      aux_o = 32'h0;
      dbl_o = 1'b0;
      pidx_o = 4'h0;
      res_o = 64'h0;
   end
endmodule
`default_nettype wire

// File: dv/cfrf_regfile_tb.sv
// Self-checking bench for the register file
`timescale 1ns/1ps
`default_nettype none
`include "cfrf_params.svh"
module cfrf_regfile_tb;
   import cfrf_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   cfrf_idx_t rs, rt, fwi;
   cfrf_pidx_t fsp, ftp, rp;
   logic fsel, dbl;
   cfrf_word_t rsd, rtd, pc, hi, lo, fwd, fcd, fcsr, aux;
   logic [63:0] fsd, ftd, res;
   cfrf_wr_t gw, fw;
   cfrf_fp_op_t op;
   cfrf_md_wr_t md;
   logic [6:0] en;
   int fails = 0;
   int cmp_count = 0;
   always #2.5 clk_i = ~clk_i;
   cfrf_pipe_model u_cfrf_pipe_model (.clk_i(clk_i), .gpr_o(gw), .fw_o(fw), .op_o(op),
      .md_o(md), .en_o(en), .aux_o(aux), .dbl_o(dbl), .pidx_o(rp), .res_o(res));
   cfrf_regfile u_cfrf_regfile (.clk_i(clk_i), .rst_i(rst_i), .rs_idx_i(rs), .rt_idx_i(rt),
      .rs_data_o(rsd), .rt_data_o(rtd), .gpr_wr_i(gw), .link_en_i(en[0]), .link_addr_i(aux),
      .pc_en_i(en[1]), .pc_next_i(aux), .pc_o(pc), .md_wr_i(md), .hi_mv_en_i(en[2]),
      .lo_mv_en_i(en[3]), .md_mv_data_i(aux), .hi_o(hi), .lo_o(lo), .fw_idx_i(fwi),
      .fw_data_o(fwd), .fs_pidx_i(fsp), .ft_pidx_i(ftp), .fs_pair_o(fsd), .ft_pair_o(ftd),
      .fw_op_i(op), .fw_wr_i(fw), .fp_res_en_i(en[6]), .fp_res_dbl_i(dbl),
      .fp_res_pidx_i(rp), .fp_res_i(res), .fc_sel_i(fsel), .fc_data_o(fcd),
      .fc_wr_en_i(en[4]), .fc_wr_data_i(aux), .fcsr_upd_en_i(en[5]), .fcsr_upd_i(aux),
      .fcsr_o(fcsr));
   task automatic end_sim();
      $display("fails=%0d compares=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0)
      begin
         $display("STATUS OK");
      end
      else
      begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string n, input cfrf_word_t e, input cfrf_word_t s);
      cmp_count++;
      if (s !== e)
      begin
         fails++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic step();
      u_cfrf_pipe_model.wait_edge();
   endtask
   function automatic cfrf_word_t gv(input int i);
      return (i == 0) ? `CFRF_WORD_ZERO : (32'hA500_0000 | 32'(i));
   endfunction
   task automatic t_gpr();
      for (int i = 0; i < 32; i++)
      begin
         u_cfrf_pipe_model.gpr_o = {1'b1, 5'(i), 32'hA500_0000 | 32'(i)};
         rs = 5'(i);
         #1;
         chk("rs fwd", gv(i), rsd);
         step();
      end
      u_cfrf_pipe_model.idle();
      for (int i = 0; i < 32; i++)
      begin
         rs = 5'(i);
         rt = 5'(31 - i);
         #1;
         chk("rs", gv(i), rsd);
         chk("rt", gv(31 - i), rtd);
         step();
      end
   endtask
   task automatic t_link_pc_md();
      // Link beats a plain write to the same register
      u_cfrf_pipe_model.gpr_o = {1'b1, 5'h1F, 32'h1111_1111};
      u_cfrf_pipe_model.en_o = 7'h0B;
      u_cfrf_pipe_model.aux_o = 32'h0040_0008;
      u_cfrf_pipe_model.md_o = {1'b1, 32'hDEAD_0001, 32'hBEEF_0002};
      step();
      u_cfrf_pipe_model.gpr_o.en = 1'b0;
      u_cfrf_pipe_model.md_o.en = 1'b0;
      u_cfrf_pipe_model.en_o = 7'h04;
      u_cfrf_pipe_model.aux_o = 32'h7777_0000;
      rs = 5'h1F;
      #1;
      chk("link", 32'h0040_0008, rsd);
      chk("pc", 32'h0040_0008, pc);
      chk("lo md", 32'hBEEF_0002, lo);
      chk("hi md", 32'hDEAD_0001, hi);
      step();
      u_cfrf_pipe_model.idle();
      chk("hi mv", 32'h7777_0000, hi);
      chk("lo kept", 32'hBEEF_0002, lo);
   endtask
   task automatic t_fp();
      for (int i = 0; i < 33; i++)
      begin
         u_cfrf_pipe_model.op_o = (i == 32) ? CFRF_FP_NONE : (i[0] ? CFRF_FP_MOVE : CFRF_FP_LOAD);
         u_cfrf_pipe_model.fw_o = {1'b1, 5'(i), 32'hF000_0000 | 32'(i % 32)};
         fwi = 5'(i);
         #1;
         chk("fw", 32'hF000_0000 | 32'(i % 32), fwd);
         step();
      end
      u_cfrf_pipe_model.fw_o = {1'b1, 5'h02, 32'h0};
      step();
      u_cfrf_pipe_model.fw_o.en = 1'b0;
      fwi = 5'h02;
      #1;
      chk("fw none", 32'hF000_0002, fwd);
      for (int p = 0; p < 16; p++)
      begin
         fsp = 4'(p);
         #1;
         chk("pair hi", 32'hF000_0000 | 32'(2 * p + 1), fsd[63:32]);
         chk("pair lo", 32'hF000_0000 | 32'(2 * p), fsd[31:0]);
         step();
      end
      u_cfrf_pipe_model.en_o = 7'h40;
      u_cfrf_pipe_model.dbl_o = 1'b1;
      u_cfrf_pipe_model.pidx_o = 4'h3;
      u_cfrf_pipe_model.res_o = 64'h1234_5678_9ABC_DEF0;
      step();
      u_cfrf_pipe_model.idle();
      fsp = 4'h3;
      #1;
      chk("dbl hi", 32'h1234_5678, fsd[63:32]);
      chk("dbl lo", 32'h9ABC_DEF0, fsd[31:0]);
      step();
      u_cfrf_pipe_model.en_o = 7'h40;
      u_cfrf_pipe_model.dbl_o = 1'b0;
      u_cfrf_pipe_model.pidx_o = 4'h4;
      u_cfrf_pipe_model.res_o = 64'hAAAA_BBBB_CCCC_DDDD;
      step();
      u_cfrf_pipe_model.idle();
      ftp = 4'h4;
      #1;
      chk("sgl hi", 32'hF000_0009, ftd[63:32]);
      chk("sgl lo", 32'hCCCC_DDDD, ftd[31:0]);
   endtask
   task automatic t_fc();
      u_cfrf_pipe_model.en_o = 7'h10;
      u_cfrf_pipe_model.aux_o = 32'h0000_0F83;
      step();
      u_cfrf_pipe_model.en_o = 7'h10;
      u_cfrf_pipe_model.aux_o = 32'hFFFF_FFFF;
      fsel = 1'b1;
      chk("csr mv", 32'h0000_0F83, fcsr);
      step();
      u_cfrf_pipe_model.en_o = 7'h20;
      u_cfrf_pipe_model.aux_o = 32'h0000_0003;
      chk("rev wr ignored", 32'h0000_0F83, fcsr);
      chk("rev", `CFRF_REV_VALUE, fcd);
      step();
      u_cfrf_pipe_model.idle();
      fsel = 1'b0;
      #1;
      chk("csr upd", 32'h0000_0003, fcd);
   endtask
   initial
   begin
      #5000;
      fails++;
      end_sim();
   end
   initial
   begin
      rs = 5'h00;
      rt = 5'h00;
      fwi = 5'h00;
      fsp = 4'h0;
      ftp = 4'h0;
      fsel = 1'b0;
      repeat (8) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      chk("pc rst", `CFRF_PC_RESET, pc);
      chk("csr rst", `CFRF_CSR_RESET, fcsr);
      t_gpr();
      t_link_pc_md();
      t_fp();
      t_fc();
      end_sim();
   end
endmodule
`default_nettype wire
